// ---- src/twpwm_defines.svh ----
`ifndef TWPWM_DEFINES_SVH
`define TWPWM_DEFINES_SVH

`define TWPWM_CTRL_OFS 4'h0
`define TWPWM_CMP_OFS 4'h4
`define TWPWM_CNT_OFS 4'h8
`define TWPWM_STAT_OFS 4'hC
`define TWPWM_CTRL_MODE_LSB 0
`define TWPWM_CTRL_ACT_LSB 2
`define TWPWM_CTRL_PRE_LSB 4
`define TWPWM_CTRL_FORCE_BIT 7
`define TWPWM_STAT_OVF_BIT 0
`define TWPWM_STAT_CMP_BIT 1
`define TWPWM_STAT_OUT_BIT 2
`define TWPWM_STAT_DIR_BIT 3
`define TWPWM_BOTTOM 8'h00
`define TWPWM_MAX 8'hFF
`define TWPWM_CTRL_RST 8'h00
`define TWPWM_CMP_RST 8'h00
`define TWPWM_DIV8 11'h007
`define TWPWM_DIV64 11'h03F
`define TWPWM_DIV256 11'h0FF
`define TWPWM_DIV1024 11'h3FF

`endif

// ---- src/twpwm_pkg.sv ----
package twpwm_pkg;
    typedef enum logic [1:0] {
        TWPWM_NORMAL = 2'h0,
        TWPWM_PHASE = 2'h1,
        TWPWM_CTC = 2'h2,
        TWPWM_FAST = 2'h3
    } twpwm_mode_type;
    typedef struct packed {
        logic force_strobe;
        logic [2:0] prescale;
        logic [1:0] action;
        twpwm_mode_type mode;
    } twpwm_ctrl_type;
    typedef struct packed {
        logic overflow_flag;
        logic compare_match_flag;
    } twpwm_flags_type;
endpackage : twpwm_pkg

// ---- src/twpwm_timer.sv ----
`timescale 1ns/1ps
`include "twpwm_defines.svh"
// Functional notes
// - Compare-clear toggle period is 2*N*(1+compare) clocks.
// - Compare-clear mode flags overflow at max.
// - Mode 3 counts bottom to max, restarts.
// - Fast non-inverting clears at match, sets bottom.
// - Fast counter clears tick after reaching max.
// - Fast mode flags overflow at every max.
// - Fast action two normal, three inverted.
// - Fast period is 256 ticks.
// - Fast extremes give spike or constant level.
// - Fast action one toggles, compare stays buffered.
// - Mode 1 counts up then down, eight bits.
// - Phase mode clears up-match, sets down-match.
// - Phase counter holds max one tick.
// - Phase mode flags overflow at bottom.
// - Phase period is 510 ticks.
// - Phase extremes hold output constant.
// - Leaving max compare fixes level at period start; code keeps the max-compare level at that top.
// - Missed up-match still applies its transition.
// - Tick is clock enable, one clock domain.
// - Action zero disconnects output from pin.
// - Compare equal top with upper bit acts at top.
module twpwm_timer
    import twpwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic wave_output,
    output logic wave_output_en,
    output logic overflow_flag,
    output logic compare_match_flag
);

    twpwm_ctrl_type ctrl_reg;
    logic [7:0] compare_buf_reg;
    logic [7:0] compare_value;
    logic [7:0] count_value;
    logic count_down_reg;
    logic out_reg;
    logic [10:0] presc_reg;
    logic timer_tick;
    logic ack_reg;
    logic [31:0] rdata_reg;
    twpwm_flags_type flags_reg;
    logic wr_ctrl;
    logic wr_cmp;
    logic wr_cnt;
    logic wr_stat;
    logic cnt_written_reg;
    logic match;
    logic at_max;
    logic at_top;
    logic [7:0] count_next;
    logic out_next;
    logic load_cmp;
    logic is_pwm;

    // One register decode function serves both read and write paths.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // A single wait state gives registered read data and a fixed answer time.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    // Writes land only at the edge where waitrequest is seen low by the master.
    assign wr_ctrl = avs_write & ack_reg & hit(avs_address, `TWPWM_CTRL_OFS);
    assign wr_cmp = avs_write & ack_reg & hit(avs_address, `TWPWM_CMP_OFS);
    assign wr_cnt = avs_write & ack_reg & hit(avs_address, `TWPWM_CNT_OFS);
    assign wr_stat = avs_write & ack_reg & hit(avs_address, `TWPWM_STAT_OFS);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h00000000;
        end else if (avs_read & ~ack_reg) begin
            rdata_reg <= 32'h00000000;
            if (hit(avs_address, `TWPWM_CTRL_OFS)) begin
                rdata_reg[6:0] <= ctrl_reg[6:0];
            end else if (hit(avs_address, `TWPWM_CMP_OFS)) begin
                rdata_reg[7:0] <= compare_buf_reg;
            end else if (hit(avs_address, `TWPWM_CNT_OFS)) begin
                rdata_reg[7:0] <= count_value;
            end else if (hit(avs_address, `TWPWM_STAT_OFS)) begin
                rdata_reg[`TWPWM_STAT_OVF_BIT] <= flags_reg.overflow_flag;
                rdata_reg[`TWPWM_STAT_CMP_BIT] <= flags_reg.compare_match_flag;
                rdata_reg[`TWPWM_STAT_OUT_BIT] <= out_reg;
                rdata_reg[`TWPWM_STAT_DIR_BIT] <= count_down_reg;
            end
        end
    end
    assign avs_readdata = rdata_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= `TWPWM_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= avs_writedata[7:0];
        end else begin
            ctrl_reg.force_strobe <= 1'b0;
        end
    end

    // Prescaler turns the core clock into a one-cycle tick enable.
    always_comb begin
        case (ctrl_reg.prescale)
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = (presc_reg[2:0] == 3'(`TWPWM_DIV8));
            3'h3: timer_tick = (presc_reg[5:0] == 6'(`TWPWM_DIV64));
            3'h4: timer_tick = (presc_reg[7:0] == 8'(`TWPWM_DIV256));
            3'h5: timer_tick = (presc_reg[9:0] == 10'(`TWPWM_DIV1024));
            default: timer_tick = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            presc_reg <= 11'h000;
        end else begin
            presc_reg <= presc_reg + 11'h001;
        end
    end

    assign is_pwm = ctrl_reg.mode[0];
    assign compare_value = compare_buf_reg;
    logic [7:0] cmp_act_reg;
    assign match = (count_value == cmp_act_reg) & ~cnt_written_reg;
    assign at_max = (count_value == `TWPWM_MAX);
    assign at_top = (ctrl_reg.mode == TWPWM_CTC) ? match : at_max;

    // Compare buffer moves to the comparator at the period boundary in PWM modes.
    always_comb begin
        case (ctrl_reg.mode)
            TWPWM_FAST: load_cmp = timer_tick & at_max;
            TWPWM_PHASE: load_cmp = timer_tick & at_max;
            default: load_cmp = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_buf_reg <= `TWPWM_CMP_RST;
        end else if (wr_cmp) begin
            compare_buf_reg <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmp_act_reg <= `TWPWM_CMP_RST;
        end else if (load_cmp) begin
            cmp_act_reg <= compare_value;
        end
    end

    always_comb begin
        case (ctrl_reg.mode)
            TWPWM_FAST: count_next = at_max ? `TWPWM_BOTTOM : count_value + 8'h01;
            TWPWM_PHASE: begin
                if (count_down_reg) begin
                    count_next = count_value - 8'h01;
                end else if (at_max) begin
                    count_next = count_value - 8'h01;
                end else begin
                    count_next = count_value + 8'h01;
                end
            end
            TWPWM_CTC: count_next = match ? `TWPWM_BOTTOM : count_value + 8'h01;
            default: count_next = count_value + 8'h01;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_value <= `TWPWM_BOTTOM;
        end else if (wr_cnt) begin
            count_value <= avs_writedata[7:0];
        end else if (timer_tick) begin
            count_value <= count_next;
        end
    end

    // A counter write blocks the compare on the following tick.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_written_reg <= 1'b0;
        end else if (wr_cnt) begin
            cnt_written_reg <= 1'b1;
        end else if (timer_tick) begin
            cnt_written_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_down_reg <= 1'b0;
        end else if (ctrl_reg.mode != TWPWM_PHASE) begin
            count_down_reg <= 1'b0;
        end else if (timer_tick) begin
            if (at_max) begin
                count_down_reg <= 1'b1;
            end else if (count_value == 8'h01 && count_down_reg) begin
                count_down_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        out_next = out_reg;
        case (ctrl_reg.mode)
            TWPWM_FAST: begin
                if (ctrl_reg.action == 2'h1) begin
                    if (match) out_next = ~out_reg;
                end else if (ctrl_reg.action[1]) begin
                    if (at_max) begin
                        out_next = ~ctrl_reg.action[0];
                    end
                    if (match && !(cmp_act_reg == `TWPWM_MAX)) begin
                        out_next = ctrl_reg.action[0];
                    end
                end
            end
            TWPWM_PHASE: begin
                if (ctrl_reg.action[1]) begin
                    if (at_max && cmp_act_reg == `TWPWM_MAX) begin
                        out_next = ~ctrl_reg.action[0];
                    end else if (at_max && compare_value != `TWPWM_MAX) begin
                        // Level at top must equal the up-match result for symmetry.
                        out_next = ctrl_reg.action[0];
                    end else if (match && !count_down_reg) begin
                        out_next = ctrl_reg.action[0];
                    end else if (match && count_down_reg) begin
                        out_next = ~ctrl_reg.action[0];
                    end
                end
            end
            default: begin
                if (match) begin
                    case (ctrl_reg.action)
                        2'h1: out_next = ~out_reg;
                        2'h2: out_next = 1'b0;
                        2'h3: out_next = 1'b1;
                        default: out_next = out_reg;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else if (ctrl_reg.force_strobe && !is_pwm) begin
            case (ctrl_reg.action)
                2'h1: out_reg <= ~out_reg;
                2'h2: out_reg <= 1'b0;
                2'h3: out_reg <= 1'b1;
                default: out_reg <= out_reg;
            endcase
        end else if (timer_tick) begin
            out_reg <= out_next;
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flags_reg <= 2'h0;
        end else begin
            if (timer_tick && ((is_pwm && !ctrl_reg.mode[1]) ?
                (count_down_reg && count_value == 8'h01) : at_max)) begin
                flags_reg.overflow_flag <= 1'b1;
            end else if (wr_stat && avs_writedata[`TWPWM_STAT_OVF_BIT]) begin
                flags_reg.overflow_flag <= 1'b0;
            end
            if (timer_tick && match) begin
                flags_reg.compare_match_flag <= 1'b1;
            end else if (wr_stat && avs_writedata[`TWPWM_STAT_CMP_BIT]) begin
                flags_reg.compare_match_flag <= 1'b0;
            end
        end
    end

    assign wave_output = out_reg;
    assign wave_output_en = (ctrl_reg.action != 2'h0);
    assign overflow_flag = flags_reg.overflow_flag;
    assign compare_match_flag = flags_reg.compare_match_flag;

endmodule : twpwm_timer

// ---- tb/twpwm_sva.sv ----
`timescale 1ns/1ps
module twpwm_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic wave_output,
    input wire logic wave_output_en,
    input wire logic overflow_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctl_reg;
    logic [7:0] cmp_reg;
    logic [11:0] quiet_reg;
    logic [11:0] gap_reg;
    logic [11:0] chg_reg;
    logic prev_reg;
    logic wr;
    logic settled;
    assign wr = avs_write && !avs_waitrequest;
    assign settled = quiet_reg > 12'h44C && ctl_reg[6:4] == 3'h1;
    // Periods are judged only long after the last write, since buffered compares lag.
    always_ff @(posedge core_clk) begin
        prev_reg <= wave_output;
        quiet_reg <= (wr || !rst_n) ? 12'h000 : quiet_reg + {11'h000, ~&quiet_reg};
        gap_reg <= (wave_output && !prev_reg) ? 12'h001 : gap_reg + {11'h000, ~&gap_reg};
        chg_reg <= (wave_output != prev_reg) ? 12'h001 : chg_reg + {11'h000, ~&chg_reg};
        ctl_reg <= !rst_n ? 8'h00 : (wr && avs_address == 4'h0) ? avs_writedata[7:0] : ctl_reg;
        cmp_reg <= !rst_n ? 8'h00 : (wr && avs_address == 4'h4) ? avs_writedata[7:0] : cmp_reg;
    end
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait on first cycle");
    answer_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("answer late");
    pin_enable_a: assert property (wr && avs_address == 4'h0 |=>
        wave_output_en == ($past(avs_writedata[3:2]) != 2'h0)) else $error("pin enable");
    ovf_sticky_a: assert property (overflow_flag && !(wr && avs_address == 4'hC
        && avs_writedata[0]) |=> overflow_flag) else $error("overflow lost");
    fast_period_a: assert property (settled && ctl_reg[1:0] == 2'h3 && ctl_reg[3]
        && wave_output && !prev_reg |-> gap_reg == 12'h100) else $error("fast period");
    phase_period_a: assert property (settled && ctl_reg[1:0] == 2'h1 && ctl_reg[3]
        && wave_output && !prev_reg |-> gap_reg == 12'h1FE) else $error("phase period");
    ctc_toggle_a: assert property (settled && ctl_reg[3:0] == 4'h6 && wave_output != prev_reg
        |-> chg_reg == {4'h0, cmp_reg} + 12'h001) else $error("toggle period");
    idle_action_a: assert property (ctl_reg[3:2] == 2'h0 && quiet_reg > 12'h004 |=>
        $stable(wave_output)) else $error("output moved");
endmodule : twpwm_sva
bind twpwm_timer twpwm_sva u_sva (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_waitrequest, .wave_output, .wave_output_en, .overflow_flag);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic wave_output;
    logic wave_output_en;
    logic overflow_flag;
    logic compare_match_flag;
    logic [31:0] rd;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 32'h6CF8;
    logic [7:0] ctl_t [12] = '{8'h1B, 8'h1F, 8'h1B, 8'h19, 8'h1D, 8'h17, 8'h16, 8'h26,
        8'h1B, 8'h1F, 8'h19, 8'h19};
    logic [7:0] cmp_t [12] = '{8'h40, 8'h40, 8'h00, 8'h40, 8'h40, 8'h10, 8'h00, 8'h03,
        8'hFF, 8'hFF, 8'h00, 8'hFF};
    twpwm_timer dut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .wave_output, .wave_output_en, .overflow_flag,
        .compare_match_flag);
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wave_output !== v && n < 4000);
    endtask : wait_lvl
    // Expected widths come from the documented slopes, never from the design.
    task automatic run(input logic [7:0] ctl, input logic [7:0] cmp);
        int hi, lo, eh, ep, k;
        k = ctl[6:4] == 3'h2 ? 8 : 1;
        ep = ctl[1:0] == 2'h1 ? 510 : 256;
        eh = ctl[1:0] == 2'h1 ? 2 * cmp : cmp + 1;
        if (ctl[3:2] == 2'h3) eh = ep - eh;
        if (ctl[3:2] == 2'h1) eh = ctl[1:0] == 2'h3 ? 256 : cmp + 1;
        if (ctl[3:2] == 2'h1) ep = 2 * eh;
        bus(1'b1, 4'h4, {24'h0, cmp});
        bus(1'b1, 4'h0, {24'h0, ctl});
        bus(1'b0, 4'h0, 32'h0);
        check("ctrl", rd, {24'h0, ctl});
        repeat (1100) @(posedge core_clk);
        if (eh == 0 || eh == ep) begin
            wait_lvl(eh == 0, lo);
            check("steady", {31'h0, wave_output}, {31'h0, eh != 0});
        end else begin
            wait_lvl(1'b0, lo);
            wait_lvl(1'b1, lo);
            wait_lvl(1'b0, hi);
            wait_lvl(1'b1, lo);
            check("high", hi, eh * k);
            check("period", hi + lo, ep * k);
        end
    endtask : run
    task automatic flags(input logic [7:0] ctl, input int lim);
        int n = 0;
        bus(1'b1, 4'h0, {24'h0, ctl[7:2], 2'h0} & 32'h0000_000F);
        bus(1'b1, 4'hC, 32'h0000_0003);
        bus(1'b0, 4'hC, 32'h0);
        check("cleared", rd[1:0], 2'h0);
        bus(1'b1, 4'h0, {24'h0, ctl});
        while (overflow_flag !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        check("ovf soon", n <= lim, 1);
        repeat (4) @(posedge core_clk);
        check("cmp flag", compare_match_flag, 1);
        check("pin off", wave_output_en, 0);
    endtask : flags
    initial begin
        repeat (90000) @(posedge core_clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", rd, 32'h0);
        flags(8'h13, 260);
        flags(8'h11, 515);
        flags(8'h12, 260);
        cmp_t[6] = 8'h01 + ($random(seed) & 32'h3E);
        for (int i = 0; i < 12; i++) run(ctl_t[i], cmp_t[i]);
        give_verdict();
    end
endmodule : testbench
